// [rtl/cecl_pkg.sv]
// cecl_pkg: encodings, field layout, reset values and access codes
// for the core extended control register bank.
// assumes: included by every file of the bank, one 200 MHz core clock.
package cecl_pkg;

    // ------------------------------------------------------------
    // register encodings (op0, op1, crn, crm, op2)
    // ------------------------------------------------------------
    localparam logic [1:0] OP0_SYS      = 2'h3;
    localparam logic [2:0] OP1_EXT      = 3'h0;
    localparam logic [3:0] CRN_IMPDEF   = 4'hF;
    localparam logic [3:0] CRM_EXT      = 4'h1;
    localparam logic [2:0] OP2_EXT_LOW  = 3'h4;
    localparam logic [2:0] OP2_EXT_SEC  = 3'h5;
    localparam logic [2:0] OP1_PRIV     = 3'h6;
    localparam logic [3:0] CRM_PRIV     = 4'h8;
    localparam logic [2:0] OP2_PRIV     = 3'h1;

    // ------------------------------------------------------------
    // exception levels
    // ------------------------------------------------------------
    localparam logic [1:0] LEVEL0 = 2'h0;
    localparam logic [1:0] LEVEL1 = 2'h1;
    localparam logic [1:0] LEVEL2 = 2'h2;
    localparam logic [1:0] LEVEL3 = 2'h3;

    // ------------------------------------------------------------
    // lower control register layout
    // ------------------------------------------------------------
    localparam int LOW_WIDTH      = 29;
    localparam int POS_TLP_OFF    = 28;
    localparam int POS_TLP_AGGR   = 27;
    localparam int POS_TLB_ABORT  = 26;
    localparam int POS_THR_L2     = 24;
    localparam int POS_THR_L3     = 22;
    localparam int POS_THR_L4     = 20;
    localparam int POS_THR_MEM    = 18;
    localparam int POS_PF_OFF     = 15;
    localparam int POS_SS_DIST    = 12;
    localparam int POS_STS_OFF    = 9;
    localparam int POS_STI_OFF    = 8;
    localparam int POS_PREFETCH_AGGRESSIVENESS    = 6;
    localparam int POS_REGION_PREFETCH_AGGRESSIVENESS   = 4;
    localparam int POS_RPF_TRAIN  = 3;
    localparam int POS_LLC_EXT    = 0;

    localparam logic [28:0] LOW_RESET = 29'h0054_3000;
    localparam logic [28:0] LOW_WMASK = 29'h1FFC_B3F9;
    localparam logic [63:0] PRIV_RESET = 64'h0000_0000_0000_0000;

    // threshold code that turns direct streaming off
    localparam logic [1:0] THR_OFF    = 2'h3;
    localparam logic [1:0] THR_TOPSET = 2'h2;

    // ------------------------------------------------------------
    // access outcome
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CECL_OK,
        CECL_UNDEF,
        CECL_TRAP_L2,
        CECL_TRAP_L3
    } cecl_result_t;

endpackage : cecl_pkg

// [rtl/cecl_access_gate.sv]
// cecl_access_gate: decodes a system register move and decides whether
// the current exception level and security state may perform it.
// assumes: inputs are stable for the cycle of the request.
`timescale 1ns/1ps
module cecl_access_gate
    import cecl_pkg::*;
(
    // instruction encoding
    input  wire logic [1:0]   op0,
    input  wire logic [2:0]   op1,
    input  wire logic [3:0]   crn,
    input  wire logic [3:0]   crm,
    input  wire logic [2:0]   op2,
    // processor state
    input  wire logic [1:0]   exceptionLevel,
    input  wire logic         nonSecure,
    input  wire logic         trapGeneral,
    input  wire logic         auxLevel2Enable,
    input  wire logic         auxLevel3Enable,
    // decode result
    output logic              hitLower,
    output logic              hitSecond,
    output logic              hitPrivate,
    output cecl_result_t      result
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire extGroup  = (op0 == OP0_SYS) && (op1 == OP1_EXT) && (crn == CRN_IMPDEF)
                     && (crm == CRM_EXT);
    wire privGroup = (op0 == OP0_SYS) && (op1 == OP1_PRIV) && (crn == CRN_IMPDEF)
                     && (crm == CRM_PRIV);

    assign hitLower   = extGroup && (op2 == OP2_EXT_LOW);
    assign hitSecond  = extGroup && (op2 == OP2_EXT_SEC);
    assign hitPrivate = privGroup && (op2 == OP2_PRIV);

    // ------------------------------------------------------------
    // permission
    // ------------------------------------------------------------
    // level 1 cannot run with trapGeneral set in non-secure state
    wire level1Absent = nonSecure && trapGeneral;
    wire level2Absent = !nonSecure;

    cecl_result_t extResult;
    cecl_result_t privResult;

    always_comb
    begin
        extResult = CECL_UNDEF;
        case (exceptionLevel)
            LEVEL0: extResult = CECL_UNDEF;
            LEVEL1:
            begin
                if (level1Absent)
                    extResult = CECL_UNDEF;
                else if (nonSecure && !auxLevel2Enable)
                    extResult = CECL_TRAP_L2;
                else if (!auxLevel3Enable)
                    extResult = CECL_TRAP_L3;
                else
                    extResult = CECL_OK;
            end
            LEVEL2:
            begin
                if (level2Absent)
                    extResult = CECL_UNDEF;
                else if (!auxLevel3Enable)
                    extResult = CECL_TRAP_L3;
                else
                    extResult = CECL_OK;
            end
            LEVEL3: extResult = CECL_OK;
            default: extResult = CECL_UNDEF;
        endcase
    end

    // private register: level 3 only, which is always secure
    assign privResult = (exceptionLevel == LEVEL3) ? CECL_OK : CECL_UNDEF;

    assign result = (hitLower || hitSecond) ? extResult :
                    hitPrivate              ? privResult : CECL_UNDEF;

endmodule : cecl_access_gate

// [rtl/cecl_stream_scaler.sv]
// cecl_stream_scaler: effective store streaming thresholds, codes below 2 raised
// by one step while this core is the only active requester in its cluster.
// assumes: soleRequester is a level from the cluster interface.
`timescale 1ns/1ps
module cecl_stream_scaler
    import cecl_pkg::*;
(
    // state
    input  wire logic         soleRequester,
    // programmed codes
    input  wire logic [1:0]   thrLevel2,
    input  wire logic [1:0]   thrLevel3,
    input  wire logic [1:0]   thrLevel4,
    input  wire logic [1:0]   thrMemory,
    // effective codes
    output logic [1:0]        effLevel2,
    output logic [1:0]        effLevel3,
    output logic [1:0]        effLevel4,
    output logic [1:0]        effMemory
);

    // ------------------------------------------------------------
    // one step up, never into the streaming-off code
    // ------------------------------------------------------------
    function automatic logic [1:0] cecl_scale(input logic [1:0] code, input logic sole);
        logic [1:0] up;
        up = code + 2'h1;
        if (sole && (code < THR_TOPSET))
            return up;
        return code;
    endfunction : cecl_scale

    assign effLevel2 = cecl_scale(thrLevel2, soleRequester);
    assign effLevel3 = cecl_scale(thrLevel3, soleRequester);
    assign effLevel4 = cecl_scale(thrLevel4, soleRequester);
    assign effMemory = cecl_scale(thrMemory, soleRequester);

endmodule : cecl_stream_scaler

// [rtl/cecl_bank.sv]
// cecl_bank: lower fields of the core extended control register, the
// all-zero second extended control register and the private control
// register, reached by system register moves; drives the field levels.
// assumes: one request per valid cycle, answered on the next edge.
`timescale 1ns/1ps
module cecl_bank
    import cecl_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // system register move request
    input  wire logic         sysRegValid,
    input  wire logic         sysRegWrite,
    input  wire logic [1:0]   op0,
    input  wire logic [2:0]   op1,
    input  wire logic [3:0]   crn,
    input  wire logic [3:0]   crm,
    input  wire logic [2:0]   op2,
    input  wire logic [63:0]  writeData,
    // processor state
    input  wire logic [1:0]   exceptionLevel,
    input  wire logic         nonSecure,
    input  wire logic         trapGeneral,
    input  wire logic         auxLevel2Enable,
    input  wire logic         auxLevel3Enable,
    input  wire logic         soleRequester,
    // answer
    output logic              sysRegDone,
    output cecl_result_t      sysRegResult,
    output logic [63:0]       readData,
    // field levels
    output logic              transient_load_predict_off,
    output logic              transient_load_predict_aggressive,
    output logic              tlb_conflict_abort_enable,
    output logic [1:0]        store_stream_threshold_level2,
    output logic [1:0]        store_stream_threshold_level3,
    output logic [1:0]        store_stream_threshold_level4,
    output logic [1:0]        store_stream_threshold_memory,
    output logic              data_prefetch_off,
    output logic [1:0]        stride_prefetch_level2_distance,
    output logic              store_stride_prefetch_off,
    output logic              store_issue_prefetch_off,
    output logic [1:0]        prefetch_aggressiveness,
    output logic [1:0]        region_prefetch_aggressiveness,
    output logic              region_prefetch_off,
    output logic              region_prefetch_single_training,
    output logic              last_level_cache_external,
    output logic [63:0]       core_private_control_value
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [28:0]  lowerReg;
    logic [63:0]  privReg;

    // ------------------------------------------------------------
    // decode and permission
    // ------------------------------------------------------------
    logic          hitLower;
    logic          hitSecond;
    logic          hitPrivate;
    cecl_result_t  gateResult;

    cecl_access_gate u_gate (
        .op0             (op0),
        .op1             (op1),
        .crn             (crn),
        .crm             (crm),
        .op2             (op2),
        .exceptionLevel  (exceptionLevel),
        .nonSecure       (nonSecure),
        .trapGeneral     (trapGeneral),
        .auxLevel2Enable (auxLevel2Enable),
        .auxLevel3Enable (auxLevel3Enable),
        .hitLower        (hitLower),
        .hitSecond       (hitSecond),
        .hitPrivate      (hitPrivate),
        .result          (gateResult)
    );

    wire granted    = sysRegValid && (gateResult == CECL_OK);
    wire writeLower = granted && sysRegWrite && hitLower;
    wire writePriv  = granted && sysRegWrite && hitPrivate;

    // reserved bits stay at zero whatever is written
    wire [28:0] next_lowerReg = (lowerReg & ~LOW_WMASK)
                              | (writeData[28:0] & LOW_WMASK);

    // second register reads zero; upper lower-register bits not held here
    wire [63:0] lowerRead  = {35'h0, lowerReg};
    wire [63:0] next_readData =
        (!granted || sysRegWrite) ? 64'h0000_0000_0000_0000 :
        hitLower                  ? lowerRead :
        hitPrivate                ? privReg   :
                                    64'h0000_0000_0000_0000;

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lowerReg <= LOW_RESET;
            privReg  <= PRIV_RESET;
        end
        else
        begin
            if (writeLower)
                lowerReg <= next_lowerReg;
            if (writePriv)
                privReg <= writeData;
        end
    end

    // ------------------------------------------------------------
    // answer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sysRegDone   <= 1'b0;
            sysRegResult <= CECL_OK;
            readData     <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            sysRegDone   <= sysRegValid;
            sysRegResult <= sysRegValid ? gateResult : CECL_OK;
            readData     <= sysRegValid ? next_readData : 64'h0000_0000_0000_0000;
        end
    end

    // ------------------------------------------------------------
    // effective stream thresholds
    // ------------------------------------------------------------
    logic [1:0] effLevel2;
    logic [1:0] effLevel3;
    logic [1:0] effLevel4;
    logic [1:0] effMemory;

    cecl_stream_scaler u_scaler (
        .soleRequester (soleRequester),
        .thrLevel2     (lowerReg[POS_THR_L2 +: 2]),
        .thrLevel3     (lowerReg[POS_THR_L3 +: 2]),
        .thrLevel4     (lowerReg[POS_THR_L4 +: 2]),
        .thrMemory     (lowerReg[POS_THR_MEM +: 2]),
        .effLevel2     (effLevel2),
        .effLevel3     (effLevel3),
        .effLevel4     (effLevel4),
        .effMemory     (effMemory)
    );

    // region prefetcher stops at its most conservative code
    wire regionOff = (lowerReg[POS_REGION_PREFETCH_AGGRESSIVENESS +: 2] == THR_OFF);

    // ------------------------------------------------------------
    // field levels, one cycle behind the stored value
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            transient_load_predict_off        <= LOW_RESET[POS_TLP_OFF];
            transient_load_predict_aggressive <= LOW_RESET[POS_TLP_AGGR];
            tlb_conflict_abort_enable         <= LOW_RESET[POS_TLB_ABORT];
            store_stream_threshold_level2     <= LOW_RESET[POS_THR_L2 +: 2];
            store_stream_threshold_level3     <= LOW_RESET[POS_THR_L3 +: 2];
            store_stream_threshold_level4     <= LOW_RESET[POS_THR_L4 +: 2];
            store_stream_threshold_memory     <= LOW_RESET[POS_THR_MEM +: 2];
            data_prefetch_off                 <= LOW_RESET[POS_PF_OFF];
            stride_prefetch_level2_distance   <= LOW_RESET[POS_SS_DIST +: 2];
            store_stride_prefetch_off         <= LOW_RESET[POS_STS_OFF];
            store_issue_prefetch_off          <= LOW_RESET[POS_STI_OFF];
            prefetch_aggressiveness           <= LOW_RESET[POS_PREFETCH_AGGRESSIVENESS +: 2];
            region_prefetch_aggressiveness    <= LOW_RESET[POS_REGION_PREFETCH_AGGRESSIVENESS +: 2];
            region_prefetch_off               <= 1'b0;
            region_prefetch_single_training   <= LOW_RESET[POS_RPF_TRAIN];
            last_level_cache_external         <= LOW_RESET[POS_LLC_EXT];
            core_private_control_value        <= PRIV_RESET;
        end
        else
        begin
            transient_load_predict_off        <= lowerReg[POS_TLP_OFF];
            transient_load_predict_aggressive <= lowerReg[POS_TLP_AGGR];
            tlb_conflict_abort_enable         <= lowerReg[POS_TLB_ABORT];
            store_stream_threshold_level2     <= effLevel2;
            store_stream_threshold_level3     <= effLevel3;
            store_stream_threshold_level4     <= effLevel4;
            store_stream_threshold_memory     <= effMemory;
            data_prefetch_off                 <= lowerReg[POS_PF_OFF];
            stride_prefetch_level2_distance   <= lowerReg[POS_SS_DIST +: 2];
            store_stride_prefetch_off         <= lowerReg[POS_STS_OFF];
            store_issue_prefetch_off          <= lowerReg[POS_STI_OFF];
            prefetch_aggressiveness           <= lowerReg[POS_PREFETCH_AGGRESSIVENESS +: 2];
            region_prefetch_aggressiveness    <= lowerReg[POS_REGION_PREFETCH_AGGRESSIVENESS +: 2];
            region_prefetch_off               <= regionOff;
            region_prefetch_single_training   <= lowerReg[POS_RPF_TRAIN];
            last_level_cache_external         <= lowerReg[POS_LLC_EXT];
            core_private_control_value        <= privReg;
        end
    end

endmodule : cecl_bank

// [test/cecl_bank_properties.sv]
// cecl_bank_properties: port-level checks of the control register bank.
// assumes: bound to cecl_bank; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module cecl_bank_properties
    import cecl_pkg::*;
(
    // clock and reset
    input wire logic         clk,
    input wire logic         reset,
    // request
    input wire logic         sysRegValid,
    input wire logic         sysRegWrite,
    input wire logic [2:0]   op1,
    input wire logic [3:0]   crm,
    input wire logic [2:0]   op2,
    input wire logic [1:0]   exceptionLevel,
    // answer and fields
    input wire logic         sysRegDone,
    input wire cecl_result_t sysRegResult,
    input wire logic [63:0]  readData,
    input wire logic         data_prefetch_off,
    input wire logic [1:0]   region_prefetch_aggressiveness,
    input wire logic         region_prefetch_off
);
    // ------------------------------------------------------------
    // decode of the watched encodings
    // ------------------------------------------------------------
    wire isLower  = {op1, crm, op2} == 10'h00C;
    wire isSecond = {op1, crm, op2} == 10'h00D;
    wire isPriv   = {op1, crm, op2} == 10'h341;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    done_after_req_a: assert property (sysRegValid |=> sysRegDone)
        else $error("no answer after request");
    done_only_req_a: assert property (!sysRegValid |=> !sysRegDone)
        else $error("answer without request");
    write_no_data_a: assert property (sysRegValid && sysRegWrite |=> readData == 64'h0)
        else $error("read data on a write");
    level0_refused_a: assert property (sysRegValid && exceptionLevel == LEVEL0
        |=> sysRegResult == CECL_UNDEF && readData == 64'h0)
        else $error("level 0 access not refused");
    refused_hold_a: assert property (sysRegValid && sysRegWrite
        && exceptionLevel == LEVEL0
        |=> ##1 $stable({data_prefetch_off, region_prefetch_aggressiveness}))
        else $error("refused write changed fields");
    private_level3_a: assert property (sysRegValid && isPriv
        && exceptionLevel != LEVEL3 |=> sysRegResult == CECL_UNDEF)
        else $error("private register reached below level 3");
    second_zero_a: assert property (sysRegValid && !sysRegWrite && isSecond
        |=> readData == 64'h0)
        else $error("second register not zero");
    reserved_zero_a: assert property (sysRegValid && !sysRegWrite && isLower
        |=> (readData & 64'hFFFF_FFFF_E003_4C06) == 64'h0)
        else $error("reserved bits not zero");
    region_off_code_a: assert property
        (region_prefetch_off == (region_prefetch_aggressiveness == 2'h3))
        else $error("region off level wrong");
endmodule : cecl_bank_properties

bind cecl_bank cecl_bank_properties i_props (.clk, .reset, .sysRegValid, .sysRegWrite,
    .op1, .crm, .op2, .exceptionLevel, .sysRegDone, .sysRegResult, .readData,
    .data_prefetch_off, .region_prefetch_aggressiveness, .region_prefetch_off);

// [test/tb.sv]
// tb: self-checking bench for the control register bank.
// assumes: cecl_pkg, cecl_bank and the bound checker compiled before it.
`timescale 1ns/1ps
module tb
    import cecl_pkg::*;
();
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [28:0] FIELD_BITS  = 29'h1FFC_B3F9;
    localparam logic [28:0] FIELD_RESET = 29'h0054_3000;
    // level, nonsecure, tge, aux2, aux3, result
    localparam logic [7:0]  ROWS [11] = '{8'h0D, 8'h4B, 8'h44, 8'h66, 8'h6B, 8'h7D,
                                          8'h8D, 8'hAB, 8'hB4, 8'hC0, 8'hF0};
    logic clk = 1'b0, reset = 1'b1, sysRegValid = 1'b0, sysRegWrite = 1'b0;
    logic [1:0] op0 = 2'h0, exceptionLevel = 2'h3;
    logic [2:0] op1 = 3'h0, op2 = 3'h0;
    logic [3:0] crn = 4'h0, crm = 4'h0;
    logic [63:0] writeData = 64'h0, privVal = 64'h0, readData, core_private_control_value;
    logic nonSecure = 1'b0, trapGeneral = 1'b0, soleRequester = 1'b0;
    logic auxLevel2Enable = 1'b0, auxLevel3Enable = 1'b0;
    logic sysRegDone, transient_load_predict_off, transient_load_predict_aggressive;
    logic tlb_conflict_abort_enable, data_prefetch_off, store_stride_prefetch_off;
    logic store_issue_prefetch_off, region_prefetch_off, region_prefetch_single_training;
    logic last_level_cache_external;
    logic [1:0] store_stream_threshold_level2, store_stream_threshold_level3;
    logic [1:0] store_stream_threshold_level4, store_stream_threshold_memory;
    logic [1:0] stride_prefetch_level2_distance, prefetch_aggressiveness;
    logic [1:0] region_prefetch_aggressiveness;
    cecl_result_t sysRegResult;
    logic [28:0] lowVal = 29'h0;
    int errors = 0, comparisons = 0, cycles = 0;

    cecl_bank i_dut (.clk, .reset, .sysRegValid, .sysRegWrite, .op0, .op1, .crn, .crm,
        .op2, .writeData, .exceptionLevel, .nonSecure, .trapGeneral, .auxLevel2Enable,
        .auxLevel3Enable, .soleRequester, .sysRegDone, .sysRegResult, .readData,
        .transient_load_predict_off, .transient_load_predict_aggressive,
        .tlb_conflict_abort_enable, .store_stream_threshold_level2,
        .store_stream_threshold_level3, .store_stream_threshold_level4,
        .store_stream_threshold_memory, .data_prefetch_off, .stride_prefetch_level2_distance,
        .store_stride_prefetch_off, .store_issue_prefetch_off, .prefetch_aggressiveness,
        .region_prefetch_aggressiveness, .region_prefetch_off,
        .region_prefetch_single_training, .last_level_cache_external,
        .core_private_control_value);

    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function logic [15:0] enc(input int k);
        // lower, second, private, unused op2, wrong crn, wrong op0
        case (k)
            0: return 16'hC78C;
            1: return 16'hC78D;
            2: return 16'hF7C1;
            4: return 16'hC70C;
            5: return 16'h878C;
            default: return 16'hC78F;
        endcase
    endfunction : enc

    function logic [1:0] eff(input logic [1:0] c);
        return (soleRequester && c < 2'h2) ? c + 2'h1 : c;
    endfunction : eff

    task state(input logic [1:0] l, input logic ns, tge, a2, a3);
        {exceptionLevel, nonSecure, trapGeneral, auxLevel2Enable, auxLevel3Enable} =
            {l, ns, tge, a2, a3};
    endtask : state

    task acc(input logic wr, input int k, input logic [63:0] d, input cecl_result_t res,
             input logic [63:0] rd);
        sysRegValid = 1'b1;
        sysRegWrite = wr;
        writeData = d;
        {op0, op1, crn, crm, op2} = enc(k);
        @(negedge clk);
        check("done", sysRegDone, 64'h1);
        check("result", sysRegResult, res);
        check("readData", readData, rd);
    endtask : acc

    task idle;
        sysRegValid = 1'b0;
        @(negedge clk);
    endtask : idle

    task see_fields(input logic [28:0] m);
        check("bits", {transient_load_predict_off, transient_load_predict_aggressive,
            tlb_conflict_abort_enable, data_prefetch_off, store_stride_prefetch_off,
            store_issue_prefetch_off, region_prefetch_single_training,
            last_level_cache_external},
            {m[28], m[27], m[26], m[15], m[9], m[8], m[3], m[0]});
        check("thresholds", {store_stream_threshold_level2, store_stream_threshold_level3,
            store_stream_threshold_level4, store_stream_threshold_memory},
            {eff(m[25:24]), eff(m[23:22]), eff(m[21:20]), eff(m[19:18])});
        check("modes", {stride_prefetch_level2_distance, prefetch_aggressiveness,
            region_prefetch_aggressiveness, region_prefetch_off},
            {m[13:12], m[7:6], m[5:4], m[5:4] == 2'h3});
    endtask : see_fields

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task reset_run;
        reset = 1'b1;
        soleRequester = 1'b0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        see_fields(FIELD_RESET);
        state(LEVEL3, 1'b0, 1'b0, 1'b0, 1'b0);
        acc(1'b0, 0, 64'h0, CECL_OK, {35'h0, FIELD_RESET});
        acc(1'b0, 2, 64'h0, CECL_OK, 64'h0);
        idle;
        lowVal = FIELD_RESET;
        privVal = 64'h0;
    endtask : reset_run

    task fields(input logic [1:0] c, input logic sole);
        logic [63:0] d;
        d = 64'(c) * 64'h0154_1050 | (c[0] ? 64'h1C00_8309 : 64'h0)
            | (c[1] ? 64'hFFFF_FFFF_E003_4C06 : 64'h0);
        lowVal = d[28:0] & FIELD_BITS;
        soleRequester = sole;
        state(LEVEL3, 1'b0, 1'b0, 1'b0, 1'b0);
        acc(1'b1, 0, d, CECL_OK, 64'h0);
        acc(1'b0, 0, 64'h0, CECL_OK, {35'h0, lowVal});
        see_fields(lowVal);
        idle;
    endtask : fields

    task private_second;
        privVal = 64'hA5A5_0F0F_3C3C_9696;
        state(LEVEL3, 1'b0, 1'b0, 1'b0, 1'b0);
        acc(1'b1, 2, privVal, CECL_OK, 64'h0);
        acc(1'b1, 1, 64'hFFFF_FFFF_FFFF_FFFF, CECL_OK, 64'h0);
        acc(1'b0, 1, 64'h0, CECL_OK, 64'h0);
        acc(1'b0, 2, 64'h0, CECL_OK, privVal);
        idle;
        check("private", core_private_control_value, privVal);
    endtask : private_second

    task access_matrix;
        logic [7:0] r;
        logic [28:0] nv;
        for (int i = 0; i < 11; i++)
        begin
            r = ROWS[i];
            nv = lowVal ^ FIELD_BITS;
            state(r[7:6], r[5], r[4], r[3], r[2]);
            acc(1'b1, 0, {35'h0, nv}, cecl_result_t'(r[1:0]), 64'h0);
            if (r[1:0] == 2'h0)
                lowVal = nv;
            acc(1'b0, 0, 64'h0, cecl_result_t'(r[1:0]),
                r[1:0] == 2'h0 ? {35'h0, lowVal} : 64'h0);
            acc(1'b0, 1, 64'h0, cecl_result_t'(r[1:0]), 64'h0);
            acc(1'b0, 2, 64'h0, r[7:6] == 2'h3 ? CECL_OK : CECL_UNDEF,
                r[7:6] == 2'h3 ? privVal : 64'h0);
            acc(1'b0, 3, 64'h0, CECL_UNDEF, 64'h0);
            acc(1'b0, 4, 64'h0, CECL_UNDEF, 64'h0);
            acc(1'b0, 5, 64'h0, CECL_UNDEF, 64'h0);
            idle;
        end
    endtask : access_matrix

    task results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial
    begin
        reset_run();
        for (int c = 0; c < 4; c++)
        begin
            fields(2'(c), 1'b0);
            fields(2'(c), 1'b1);
        end
        private_second();
        access_matrix();
        reset_run();
        results();
    end
endmodule : tb
